// file: rtl/qush_top.sv
// host signalling of a four-channel uart: bus decode, reset, status and apb view
// Notes on behaviour
// RL1: host bus is 8 data bits, 3 register address bits, selects and strobes.
// RL2: host cycles complete from strobes and selects alone, no baud clock.
// RL3: all channels share one data bus; select decoding picks the channel.
// RL4: reset pin held over 40 ns resets registers and serial outputs.
// RL5: both divisor bytes zero: high reads identity code, low reads revision.
// RL6: strobe style: one select low picks that channel; all high none.
// RL7: all four selects low: one write reaches every channel.
// RL8: host never reads with all four selects low.
// RL9: direction style: common select low, A4,A3 pick channel A to D.
// RL10: channel address bits used only in direction style.
// RL11: bus style strap high gives strobe style, low gives direction style.
// RL12: strobe style: irq style strap and modem bit 3 gate interrupt drive.
// RL13: modem bit 5 set: any received character resumes held transmitter.
// RL14: prescale strap presets divide by 1 or 4; modem bit 7 overrides.
// RL15: one summary register shows all tx and rx ready levels.
// RL16: fifo off: transmit interrupt low with byte held, high when empty.
// RL17: fifo on: transmit interrupt high below trigger or empty.
// RL18: receive interrupt high with byte held or fifo at trigger.
// RL19: rx ready low while data available, high when none, outside block mode.
// RL20: block mode: rx ready falls at trigger or timeout, rises when empty.
// RL21: tx ready low when holding or fifo empty, outside block mode.
// RL22: block mode: tx ready low while a free slot, high when full.
// RL23: direction style: reset pin is active low, same 40 ns minimum.
// RL24: during reset serial tx outputs are high and rx inputs ignored.
// RL25: no channel selected: data bus undriven, strobes ignored.
`timescale 1ns/1ps
`include "qush_map.svh"
module qush_top #(
    parameter logic [7:0] ID_CODE  = 8'hA5, // arbitrary value
    parameter logic [7:0] REV_CODE = 8'h5A  // arbitrary value
) (
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_SYS_RST,
    input  wire logic        I_BUS_STYLE_SEL,
    input  wire logic        I_IRQ_STYLE_SEL,
    input  wire logic        I_PRESCALE_SEL,
    input  wire logic        I_RESET_PIN,
    input  wire logic [3:0]  I_CH_SEL_N,
    input  wire logic        I_COMMON_SEL_N,
    input  wire logic        I_RD_STROBE_N,
    input  wire logic        I_WR_STROBE_N,
    input  wire logic        I_RW_N,
    input  wire logic [4:0]  I_ADDR,
    input  wire logic [7:0]  I_DATA,
    output logic      [7:0]  O_DATA,
    output logic             O_DATA_OE,
    input  wire logic [3:0]  I_SER_RX,
    output logic      [3:0]  O_SER_RX,
    input  wire logic [3:0]  I_SER_TX,
    output logic      [3:0]  O_SER_TX,
    output logic             O_CH_RST,
    input  wire logic [3:0]  I_TX_EMPTY,
    input  wire logic [3:0]  I_TX_FULL,
    input  wire logic [3:0]  I_TX_BELOW_TRIG,
    input  wire logic [3:0]  I_TSR_EMPTY,
    input  wire logic [3:0]  I_RX_AVAIL,
    input  wire logic [3:0]  I_RX_AT_TRIG,
    input  wire logic [3:0]  I_RX_TIMEOUT,
    output logic      [3:0]  O_IRQ,
    output logic      [3:0]  O_IRQ_OE,
    output logic      [3:0]  O_TX_READY_N,
    output logic      [3:0]  O_RX_READY_N,
    output logic      [3:0]  O_HOST_WR,
    output logic      [3:0]  O_HOST_RD,
    output logic      [2:0]  O_HOST_ADDR,
    output logic      [7:0]  O_HOST_WDATA,
    input  wire logic [31:0] I_HOST_RDATA,
    output logic      [63:0] O_DIVISOR,
    output logic      [3:0]  O_PRESCALE_DIV4,
    output logic      [3:0]  O_ANY_RESUME,
    output logic      [3:0]  O_FIFO_EN,
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR
);
    localparam logic [2:0] RC = 3'(`QUSH_RST_CYC);

    qush_pkg::qush_top_type q;
    qush_pkg::qush_top_type d;
    logic [28:0]      st;
    logic [3:0]       ch_vec;
    logic             act;
    logic             rd;
    logic             pin_act;
    logic             ch_rst;
    logic [3:0][7:0]  rd_c;
    logic [3:0]       irq_c;
    logic [3:0]       txr_c;
    logic [3:0]       rxr_c;
    logic [3:0]       gate_c;

    // host bus pins, straps, reset pin and serial rx inputs reach the core domain through the three-stage filter
    qush_sync #(.W(29), .RST_VAL(`QUSH_SYNC_IDLE)) u_sync (
        .i_clk    (I_CORE_CLK),
        .i_rst    (I_SYS_RST),
        .i_async  ({I_SER_RX, I_PRESCALE_SEL, I_IRQ_STYLE_SEL, I_BUS_STYLE_SEL, I_RESET_PIN,
                    I_DATA, I_ADDR, I_RW_N, I_WR_STROBE_N, I_RD_STROBE_N, I_COMMON_SEL_N,
                    I_CH_SEL_N}),
        .o_stable (st)
    );

    always_comb begin
        ch_vec = 4'h0;
        if (q.mode16) begin
            ch_vec = ~st[3:0]; // [RL6] [RL7] [RL10]
        end else if (!st[4]) begin
            ch_vec = 4'h1 << st[12:11]; // [RL9]
        end
    end

    // strobe style needs exactly one strobe; both low is a test cycle and is ignored
    assign act = q.mode16 ? ((ch_vec != 4'h0) && (st[5] ^ st[6])) : !st[4]; // [RL11] [RL25]
    assign rd  = q.mode16 ? !st[5] : st[7]; // [RL11]
    // the reset pin counts only once straps and filter are valid, so boot gives no false pulse
    assign pin_act = (q.boot == `QUSH_BOOT_CYC)
                     && (q.mode16 ? st[21] : !st[21]); // [RL4] [RL23]
    assign ch_rst  = I_SYS_RST || (q.boot != `QUSH_BOOT_CYC) || q.soft_rst || q.pin_rst;

    for (genvar i = 0; i < 4; i++) begin : g_ch
        qush_chan #(.ID_CODE(ID_CODE), .REV_CODE(REV_CODE)) u_chan (
            .i_clk        (I_CORE_CLK),
            .i_rst        (ch_rst),
            .i_presel     (q.presel),
            .i_wr         (q.host_wr[i]),
            .i_addr       (q.addr),
            .i_wdata      (q.wdata),
            .i_ext_rdata  (I_HOST_RDATA[8*i+:8]),
            .i_tx_empty   (I_TX_EMPTY[i]),
            .i_tx_full    (I_TX_FULL[i]),
            .i_tx_below   (I_TX_BELOW_TRIG[i]),
            .i_tsr_empty  (I_TSR_EMPTY[i]),
            .i_rx_avail   (I_RX_AVAIL[i]),
            .i_rx_trig    (I_RX_AT_TRIG[i]),
            .i_rx_tout    (I_RX_TIMEOUT[i]),
            .o_rdata      (rd_c[i]),
            .o_irq        (irq_c[i]),
            .o_tx_ready_n (txr_c[i]),
            .o_rx_ready_n (rxr_c[i]),
            .o_irq_gate   (gate_c[i]),
            .o_fifo_en    (O_FIFO_EN[i]),
            .o_div4       (O_PRESCALE_DIV4[i]),
            .o_any_resume (O_ANY_RESUME[i]),
            .o_divisor    (O_DIVISOR[16*i+:16])
        );
    end

    always_comb begin
        d         = q;
        d.host_wr = 4'h0;
        d.host_rd = 4'h0;
        d.pready  = 1'b0;
        d.pslverr = 1'b0;
        // straps are taken only while the channels are held in reset
        if (ch_rst) begin
            d.mode16 = st[22];
            d.irq_style_select = st[23];
            d.presel = st[24]; // [RL14]
        end
        if (q.boot != `QUSH_BOOT_CYC) begin
            d.boot = q.boot + 3'h1;
        end
        if (pin_act) begin
            if (q.rst_cnt != RC) begin
                d.rst_cnt = q.rst_cnt + 3'h1;
            end
        end else begin
            d.rst_cnt = 3'h0;
        end
        d.pin_rst = pin_act && (q.rst_cnt >= RC - 3'h1); // [RL4] [RL23]
        // a cycle is latched while active and acted on when it ends
        if (act && !ch_rst) begin
            d.act  = 1'b1;
            d.rd   = rd;
            d.ch   = ch_vec; // [RL3]
            d.addr = st[10:8]; // [RL1]
            if (!rd) begin
                d.wdata = st[20:13];
            end
        end else begin
            if (q.act && !ch_rst) begin
                if (q.rd) begin
                    d.host_rd = q.ch;
                end else begin
                    d.host_wr = q.ch; // [RL2] [RL7]
                end
            end
            d.act = 1'b0;
        end
        d.data_oe  = q.act && q.rd && act && !ch_rst; // [RL25]
        d.data_out = 8'h00;
        // lowest selected channel answers a read
        for (int i = 3; i >= 0; i--) begin
            if (q.ch[i]) begin
                d.data_out = rd_c[i]; // [RL8]
            end
        end
        for (int i = 0; i < 4; i++) begin
            d.irq_oe[i] = !q.mode16 || q.irq_style_select || gate_c[i]; // [RL12]
            d.irq[i]    = irq_c[i] && (!q.mode16 || q.irq_style_select || gate_c[i]);
        end
        d.txr_n  = txr_c;
        d.rxr_n  = rxr_c;
        d.ser_tx = ch_rst ? 4'hF : I_SER_TX; // [RL24]
        d.ser_rx = ch_rst ? 4'hF : st[28:25]; // [RL24]
        d.rst_o  = ch_rst;
        if (I_PSEL && I_PENABLE && !q.pready) begin
            d.pready = 1'b1;
            d.prdata = 32'h00000000;
            if (I_PADDR == `QUSH_APB_SUMMARY) begin
                d.prdata = {24'h000000, q.rxr_n, q.txr_n}; // [RL15]
            end else if (I_PADDR == `QUSH_APB_CTRL) begin
                if (I_PWRITE) begin
                    d.soft_rst = I_PWDATA[`QUSH_CTRL_SOFT_RST];
                end
                d.prdata = {31'h00000000, q.soft_rst};
            end else begin
                d.pslverr = 1'b1;
            end
        end
        if (I_SYS_RST) begin
            d        = '0;
            d.txr_n  = 4'hF;
            d.rxr_n  = 4'hF;
            d.ser_tx = 4'hF;
            d.ser_rx = 4'hF;
            d.rst_o  = 1'b1;
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        q <= d;
    end

    assign O_DATA       = q.data_out;
    assign O_DATA_OE    = q.data_oe;
    assign O_SER_RX     = q.ser_rx;
    assign O_SER_TX     = q.ser_tx;
    assign O_CH_RST     = q.rst_o;
    assign O_IRQ        = q.irq;
    assign O_IRQ_OE     = q.irq_oe;
    assign O_TX_READY_N = q.txr_n;
    assign O_RX_READY_N = q.rxr_n;
    assign O_HOST_WR    = q.host_wr;
    assign O_HOST_RD    = q.host_rd;
    assign O_HOST_ADDR  = q.addr;
    assign O_HOST_WDATA = q.wdata;
    assign O_PRDATA     = q.prdata;
    assign O_PREADY     = q.pready;
    assign O_PSLVERR    = q.pslverr;

    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_SYS_RST);

    sequence s_pin_pulse;
        pin_act [*4];
    endsequence
    sequence s_bcast_end;
        (q.act && !q.rd && q.ch == 4'hF && !ch_rst) ##1 !q.act;
    endsequence

    a_pin_reset: assert property (s_pin_pulse |=> q.pin_rst) // [RL4]
        else $error("long reset pulse not honoured");
    a_pin_short: assert property ($rose(q.pin_rst) |-> $past(pin_act, 4)) // [RL23]
        else $error("reset taken from a short pulse");
    a_ser_hold: assert property (ch_rst |=> (O_SER_TX == 4'hF && O_SER_RX == 4'hF)) // [RL24]
        else $error("serial lines not idle in reset");
    a_idle_undriven: assert property (!q.act |=> !O_DATA_OE) // [RL25]
        else $error("data bus driven while not selected");
    a_bcast_write: assert property (s_bcast_end |-> O_HOST_WR == 4'hF) // [RL7]
        else $error("broadcast write missed a channel");
    a_mode68_sel: assert property ((!q.mode16 && act && !ch_rst) // [RL9]
        |=> q.ch == (4'h1 << $past(st[12:11])))
        else $error("direction style channel decode wrong");
    a_irq_gate: assert property ((q.mode16 && !q.irq_style_select) |=> O_IRQ_OE == $past(gate_c)) // [RL12]
        else $error("gated interrupt enable wrong");
    a_irq_cont: assert property ((!q.mode16 || q.irq_style_select) |=> O_IRQ_OE == 4'hF) // [RL12]
        else $error("continuous interrupt not driven");
    a_apb_ready: assert property ((I_PSEL && I_PENABLE && !O_PREADY)
        |=> O_PREADY ##1 !O_PREADY)
        else $error("apb ready not a single wait state");
endmodule // qush_top

// file: include/qush_map.svh
// offsets, field positions, reset values and timing counts of the host signalling block
`ifndef QUSH_MAP_SVH
`define QUSH_MAP_SVH
`define QUSH_CLK_PERIOD_NS 10
`define QUSH_RST_MIN_NS 40
`define QUSH_RST_CYC ((`QUSH_RST_MIN_NS + `QUSH_CLK_PERIOD_NS - 1) / `QUSH_CLK_PERIOD_NS)
`define QUSH_BOOT_CYC 3'h5
`define QUSH_HREG_FCR 3'h3
`define QUSH_HREG_MCR 3'h4
`define QUSH_HREG_FEATURE_CONTROL_REG 3'h5
`define QUSH_HREG_DLL 3'h6
`define QUSH_HREG_DLM 3'h7
`define QUSH_APB_SUMMARY 8'h00
`define QUSH_APB_CTRL 8'h04
`define QUSH_FCR_FIFO_EN 0
`define QUSH_FCR_BLOCK 3
`define QUSH_MCR_IRQ_GATE 3
`define QUSH_MCR_ANY_RESUME 5
`define QUSH_MCR_DIV4 7
`define QUSH_FEATURE_CONTROL_REG_TX_TSR 3
`define QUSH_CTRL_SOFT_RST 0
`define QUSH_RST_FCR 8'h00
`define QUSH_RST_MCR 8'h00
`define QUSH_RST_FEATURE_CONTROL_REG 8'h00
`define QUSH_RST_DIV 8'h00
`define QUSH_SYNC_IDLE 29'h1E0000FF
`endif

// file: include/qush_pkg.sv
// state types of the host signalling block
package qush_pkg;
    typedef struct packed {
        logic [7:0] fifo_control_reg;
        logic [7:0] modem_control_reg;
        logic [7:0] feature_control_reg;
        logic [7:0] dll;
        logic [7:0] divisor_high;
        logic       rxr_n;
    } qush_chan_type;

    typedef struct packed {
        logic        mode16;
        logic        irq_style_select;
        logic        presel;
        logic [2:0]  boot;
        logic [2:0]  rst_cnt;
        logic        pin_rst;
        logic        act;
        logic        rd;
        logic [3:0]  ch;
        logic [2:0]  addr;
        logic [7:0]  wdata;
        logic [7:0]  data_out;
        logic        data_oe;
        logic [3:0]  irq;
        logic [3:0]  irq_oe;
        logic [3:0]  txr_n;
        logic [3:0]  rxr_n;
        logic [3:0]  ser_tx;
        logic [3:0]  ser_rx;
        logic        rst_o;
        logic [3:0]  host_wr;
        logic [3:0]  host_rd;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
        logic        soft_rst;
    } qush_top_type;
endpackage

// file: rtl/qush_sync.sv
// three-stage input synchroniser that takes a bit once stages two and three agree
`timescale 1ns/1ps
module qush_sync #(
    parameter int          W       = 8,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_stable
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] st;
    } qush_sync_type;

    qush_sync_type q;
    qush_sync_type d;

    always_comb begin
        d    = q;
        d.s1 = i_async;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.st = (q.s3 & ~(q.s2 ^ q.s3)) | (q.st & (q.s2 ^ q.s3));
        if (i_rst) begin
            d = {4{RST_VAL}};
        end
    end

    always_ff @(posedge i_clk) begin
        q <= d;
    end

    assign o_stable = q.st;

    a_sync_agree: assert property (@(posedge i_clk) disable iff (i_rst)
        ((o_stable ^ $past(o_stable)) & $past(q.s2 ^ q.s3)) == '0)
        else $error("stable bit changed without agreement");
endmodule // qush_sync

// file: rtl/qush_chan.sv
// per-channel control registers, identity readback and ready and interrupt levels
`timescale 1ns/1ps
`include "qush_map.svh"
module qush_chan #(
    parameter logic [7:0] ID_CODE  = 8'hA5,
    parameter logic [7:0] REV_CODE = 8'h5A
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_presel,
    input  wire logic        i_wr,
    input  wire logic [2:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic [7:0]  i_ext_rdata,
    input  wire logic        i_tx_empty,
    input  wire logic        i_tx_full,
    input  wire logic        i_tx_below,
    input  wire logic        i_tsr_empty,
    input  wire logic        i_rx_avail,
    input  wire logic        i_rx_trig,
    input  wire logic        i_rx_tout,
    output logic      [7:0]  o_rdata,
    output logic             o_irq,
    output logic             o_tx_ready_n,
    output logic             o_rx_ready_n,
    output logic             o_irq_gate,
    output logic             o_fifo_en,
    output logic             o_div4,
    output logic             o_any_resume,
    output logic      [15:0] o_divisor
);
    qush_pkg::qush_chan_type q;
    qush_pkg::qush_chan_type d;
    logic blk;
    logic tx_done;

    assign blk     = q.fifo_control_reg[`QUSH_FCR_FIFO_EN] & q.fifo_control_reg[`QUSH_FCR_BLOCK];
    assign tx_done = q.feature_control_reg[`QUSH_FEATURE_CONTROL_REG_TX_TSR] ? i_tsr_empty : i_tx_empty;

    always_comb begin
        d = q;
        if (i_wr) begin
            if (i_addr == `QUSH_HREG_FCR) begin
                d.fifo_control_reg = i_wdata;
            end else if (i_addr == `QUSH_HREG_MCR) begin
                d.modem_control_reg = i_wdata;
            end else if (i_addr == `QUSH_HREG_FEATURE_CONTROL_REG) begin
                d.feature_control_reg = i_wdata;
            end else if (i_addr == `QUSH_HREG_DLL) begin
                d.dll = i_wdata;
            end else if (i_addr == `QUSH_HREG_DLM) begin
                d.divisor_high = i_wdata;
            end
        end
        if (!blk) begin
            d.rxr_n = !i_rx_avail; // [RL19]
        end else if (i_rx_trig || i_rx_tout) begin
            d.rxr_n = 1'b0; // [RL20]
        end else if (!i_rx_avail) begin
            d.rxr_n = 1'b1; // [RL20]
        end
        if (i_rst) begin
            d.fifo_control_reg   = `QUSH_RST_FCR;
            d.modem_control_reg   = `QUSH_RST_MCR;
            d.modem_control_reg[`QUSH_MCR_DIV4] = !i_presel; // [RL14]
            d.feature_control_reg  = `QUSH_RST_FEATURE_CONTROL_REG;
            d.dll   = `QUSH_RST_DIV;
            d.divisor_high   = `QUSH_RST_DIV;
            d.rxr_n = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        q <= d;
    end

    always_comb begin
        o_rdata = i_ext_rdata;
        if (i_addr == `QUSH_HREG_FCR) begin
            o_rdata = q.fifo_control_reg;
        end else if (i_addr == `QUSH_HREG_MCR) begin
            o_rdata = q.modem_control_reg;
        end else if (i_addr == `QUSH_HREG_FEATURE_CONTROL_REG) begin
            o_rdata = q.feature_control_reg;
        end else if (i_addr == `QUSH_HREG_DLL) begin
            o_rdata = ({q.divisor_high, q.dll} == 16'h0000) ? REV_CODE : q.dll; // [RL5]
        end else if (i_addr == `QUSH_HREG_DLM) begin
            o_rdata = ({q.divisor_high, q.dll} == 16'h0000) ? ID_CODE : q.divisor_high; // [RL5]
        end
    end

    // fifo disabled: holding register only; enabled: trigger level or empty
    assign o_irq = (q.fifo_control_reg[`QUSH_FCR_FIFO_EN] ? (i_tx_below || tx_done) : tx_done) // [RL16] [RL17]
                 || (q.fifo_control_reg[`QUSH_FCR_FIFO_EN] ? i_rx_trig : i_rx_avail); // [RL18]
    assign o_tx_ready_n = blk ? i_tx_full : !i_tx_empty; // [RL21] [RL22]
    assign o_rx_ready_n = q.rxr_n;
    assign o_irq_gate   = q.modem_control_reg[`QUSH_MCR_IRQ_GATE];
    assign o_fifo_en    = q.fifo_control_reg[`QUSH_FCR_FIFO_EN];
    assign o_div4       = q.modem_control_reg[`QUSH_MCR_DIV4]; // [RL14]
    assign o_any_resume = q.modem_control_reg[`QUSH_MCR_ANY_RESUME]; // [RL13]
    assign o_divisor    = {q.divisor_high, q.dll};

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_id_read: assert property ((i_addr == `QUSH_HREG_DLM && q.dll == 8'h00 // [RL5]
        && q.divisor_high == 8'h00) |-> o_rdata == ID_CODE)
        else $error("identity code not returned");
    a_rx_block_fall: assert property ((blk && (i_rx_trig || i_rx_tout)) // [RL20]
        |=> !o_rx_ready_n)
        else $error("block mode rx ready did not fall");
    a_rx_block_hold: assert property ((blk && $past(blk) && !o_rx_ready_n // [RL20]
        && i_rx_avail) |=> !o_rx_ready_n)
        else $error("block mode rx ready rose before empty");
    a_tx_block: assert property (blk |-> o_tx_ready_n == i_tx_full) // [RL22]
        else $error("block mode tx ready wrong");
    a_prescale_boot: assert property ($fell(i_rst) |-> o_div4 == !$past(i_presel)) // [RL14]
        else $error("prescaler not preset from strap");
endmodule // qush_chan

// file: sim/qush_host.sv
// host processor model on the shared 8-bit bus
`timescale 1ns/1ps
module qush_host (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_data,
    input  wire logic       i_data_oe,
    output logic      [3:0] o_sel_n = 4'hF,
    output logic            o_csel_n = 1'b1,
    output logic            o_rd_n = 1'b1,
    output logic            o_wr_n = 1'b1,
    output logic            o_rw_n = 1'b1,
    output logic      [4:0] o_addr = 5'h00,
    output logic      [7:0] o_data = 8'h00
);
    task automatic cyc(input logic [3:0] sel, input logic cs, input logic rd,
                       input logic [4:0] a, input logic [7:0] wd, output logic [8:0] q);
        int n;
        n = 0;
        if (rd && sel == 4'h0) sel = 4'hE;
        @(posedge i_clk);
        o_sel_n <= sel;
        o_csel_n <= cs;
        o_rw_n <= rd;
        o_addr <= a;
        o_data <= rd ? ~o_data : wd;
        o_rd_n <= !rd;
        o_wr_n <= rd;
        while (n < 12 && !(rd && i_data_oe === 1'b1)) begin
            @(posedge i_clk);
            n++;
        end
        q = {i_data_oe, i_data};
        o_sel_n <= 4'hF;
        o_csel_n <= 1'b1;
        o_rd_n <= 1'b1;
        o_wr_n <= 1'b1;
        o_data <= ~o_data;
        repeat (8) @(posedge i_clk);
    endtask
endmodule // qush_host

// file: sim/tb.sv
// self-checking bench of the quad uart host signalling block
`timescale 1ns/1ps
module tb;
    localparam logic [7:0] ID  = 8'h3C; // arbitrary value
    localparam logic [7:0] REV = 8'h07; // arbitrary value
    logic        clk = 1'b0, rst = 1'b1, bsel = 1'b1, rpin = 1'b0;
    logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, e, isel = 1'b1, pres = 1'b1;
    logic [3:0]  txe = 4'h0, rxa = 4'h0, stx = 4'h6, txf = 4'h0;
    logic [3:0]  srx, fen, hwr, hrd;
    logic [2:0]  hao;
    logic [7:0]  hwo, hstb;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwd = 32'h0, prd, r;
    logic [3:0]  sel_n, txr, rxr, irq, ioe, tso, div4, anyr;
    logic        csel_n, rd_n, wr_n, rw_n, ooe, chrst, prdy, perr;
    logic [4:0]  haddr;
    logic [7:0]  hdata, odata;
    logic [63:0] div;
    logic [8:0]  q;
    int          mismatches = 0, checks_done = 0, cycles = 0;
    initial forever #5 clk = ~clk;
    qush_host host (.i_clk(clk), .i_data(odata), .i_data_oe(ooe), .o_sel_n(sel_n),
        .o_csel_n(csel_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_rw_n(rw_n),
        .o_addr(haddr), .o_data(hdata));
    qush_top #(.ID_CODE(ID), .REV_CODE(REV)) dut (
        .I_CORE_CLK(clk), .I_SYS_RST(rst), .I_BUS_STYLE_SEL(bsel),
        .I_IRQ_STYLE_SEL(isel), .I_PRESCALE_SEL(pres), .I_RESET_PIN(rpin),
        .I_CH_SEL_N(sel_n), .I_COMMON_SEL_N(csel_n), .I_RD_STROBE_N(rd_n),
        .I_WR_STROBE_N(wr_n), .I_RW_N(rw_n), .I_ADDR(haddr), .I_DATA(hdata),
        .O_DATA(odata), .O_DATA_OE(ooe), .I_SER_RX(stx), .O_SER_RX(srx),
        .I_SER_TX(stx), .O_SER_TX(tso), .O_CH_RST(chrst), .I_TX_EMPTY(txe),
        .I_TX_FULL(txf), .I_TX_BELOW_TRIG(txe), .I_TSR_EMPTY(txe),
        .I_RX_AVAIL(rxa), .I_RX_AT_TRIG(rxa), .I_RX_TIMEOUT(rxa), .O_IRQ(irq),
        .O_IRQ_OE(ioe), .O_TX_READY_N(txr), .O_RX_READY_N(rxr), .O_HOST_WR(hwr),
        .O_HOST_RD(hrd), .O_HOST_ADDR(hao), .O_HOST_WDATA(hwo), .I_HOST_RDATA(32'h0),
        .O_DIVISOR(div), .O_PRESCALE_DIV4(div4), .O_ANY_RESUME(anyr),
        .O_FIFO_EN(fen), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
        .I_PADDR(paddr), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(prdy),
        .O_PSLVERR(perr));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            mismatches++;
            complete_run();
        end
    end
    // keep the last host strobe pair, read channels high nibble, write channels low
    always @(posedge clk) begin
        if ((hwr | hrd) != 4'h0) begin
            hstb <= {hrd, hwr};
        end
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (prdy !== 1'b1);
        r = prd;
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (chrst !== 1'b0 && n < 40) begin
            @(posedge clk);
            n++;
        end
        check(chrst, 1'b0);
    endtask
    task automatic t_status();
        txe <= 4'h5;
        rxa <= 4'h3;
        repeat (4) @(posedge clk);
        check(txr, 4'hA);
        check(rxr, 4'hC);
        check(irq, 4'h7);
        check(ioe, 4'hF);
        apb(1'b0, 8'h00, 32'h0);
        check(r, 32'hCA);
        apb(1'b0, 8'h10, 32'h0);
        check(e, 1'b1);
        apb(1'b1, 8'h04, 32'h1);
        repeat (3) @(posedge clk);
        check(chrst, 1'b1);
        apb(1'b1, 8'h04, 32'h0);
        wait_ready();
        $display("test status done");
    endtask
    task automatic t_host();
        host.cyc(4'hD, 1'b1, 1'b1, 5'h07, 8'h00, q);
        check(q, {1'b1, ID});
        host.cyc(4'hD, 1'b1, 1'b1, 5'h06, 8'h00, q);
        check(q, {1'b1, REV});
        host.cyc(4'hF, 1'b1, 1'b1, 5'h07, 8'h00, q);
        check(q[8], 1'b0);
        check(div4, 4'h0);
        host.cyc(4'h0, 1'b1, 1'b0, 5'h04, 8'hA0, q);
        check(anyr, 4'hF);
        check(div4, 4'hF);
        host.cyc(4'hB, 1'b1, 1'b0, 5'h1E, 8'h34, q);
        check(div, 64'h0000_0034_0000_0000);
        check(hwo, 8'h34);
        check(hao, 3'h6);
        check(hstb, 8'h04);
        host.cyc(4'hB, 1'b1, 1'b1, 5'h07, 8'h00, q);
        check(q, 9'h100);
        check(hstb, 8'h40);
        $display("test host bus done");
    endtask
    task automatic t_fifo();
        host.cyc(4'h0, 1'b1, 1'b0, 5'h03, 8'h09, q);
        txf <= 4'h3;
        rxa <= 4'h5;
        repeat (4) @(posedge clk);
        check(fen, 4'hF);
        check(txr, 4'h3);
        check(rxr, 4'hA);
        rxa <= 4'h0;
        repeat (4) @(posedge clk);
        check(rxr, 4'hF);
        check(irq, 4'h5);
        $display("test fifo modes done");
    endtask
    task automatic pin_reset(input logic act);
        rpin <= act;
        repeat (12) @(posedge clk);
        check(chrst, 1'b1);
        rpin <= !act;
        wait_ready();
        check(div, 64'h0);
        $display("test pin reset done");
    endtask
    task automatic t_dir();
        bsel <= 1'b0;
        pres <= 1'b0;
        rpin <= 1'b1;
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        wait_ready();
        check(div4, 4'hF);
        check(ioe, 4'hF);
        host.cyc(4'hF, 1'b0, 1'b1, 5'h1F, 8'h00, q);
        check(q, {1'b1, ID});
        host.cyc(4'hF, 1'b0, 1'b0, 5'h16, 8'h12, q);
        check(div, 64'h0000_0012_0000_0000);
        pin_reset(1'b0);
        $display("test direction style done");
    endtask
    initial begin
        repeat (3) @(posedge clk);
        check(tso, 4'hF);
        check(srx, 4'hF);
        check(chrst, 1'b1);
        rst <= 1'b0;
        wait_ready();
        check(tso, 4'h6);
        check(srx, 4'h6);
        t_status();
        t_host();
        t_fifo();
        isel <= 1'b0;
        pin_reset(1'b1);
        check(ioe, 4'h0);
        check(irq, 4'h0);
        host.cyc(4'h0, 1'b1, 1'b0, 5'h04, 8'h08, q);
        check(ioe, 4'hF);
        check(irq, 4'h5);
        t_dir();
        complete_run();
    end
endmodule // tb
